/* logic/ofrc_core.sv */
`timescale 1ns/1ps
`default_nettype none
module ofrc_core
  import ofrc_pkg::*;
#(
  parameter int HICCUP_CYCLES = HICCUP_CYC_DEF
) (
  // clock and reset
  input  wire logic               CLOCK,
  input  wire logic               RST_B,
  // enable and fault clearing
  input  wire logic               ENABLE_PIN,
  input  wire logic               ENABLE_ACTIVE_LOW,
  input  wire logic               CLEAR_FAULTS,
  // measurements and analog comparators
  input  wire logic [11:0]        VOUT_MEAS,
  input  wire logic [11:0]        VOUT_NOM,
  input  wire logic               OVERCURRENT_DET_PIN,
  input  wire logic               REVERSE_CURRENT_DET_PIN,
  // voltage fault configuration
  input  wire logic [7:0]         OV_PCT,
  input  wire logic [7:0]         UV_PCT,
  input  wire ofrc_pkg::ofrc_resp_e VOLTAGE_FAULT_OPTIONS,
  input  wire logic               CROWBAR_DISABLE,
  // current fault configuration
  input  wire ofrc_pkg::ofrc_resp_e OVERCURRENT_RESPONSE_SETTING,
  input  wire ofrc_pkg::ofrc_resp_e REVERSE_CURRENT_RESPONSE_SETTING,
  // output good configuration
  input  wire logic [7:0]         PGOOD_ON_PCT,
  input  wire logic [7:0]         PGOOD_OFF_PCT,
  input  wire logic [7:0]         PGOOD_DELAY,
  input  wire logic               VENDOR_CONFIG_PUSH_PULL,
  // sequencing times in ticks
  input  wire logic [7:0]         TON_DELAY,
  input  wire logic [7:0]         TON_RISE,
  input  wire logic [7:0]         TOFF_DELAY,
  input  wire logic [7:0]         TOFF_FALL,
  input  wire logic               SOFT_STOP_EN,
  // synchronization and interleave
  input  wire ofrc_pkg::ofrc_sync_e SYNC_MODE,
  input  wire logic               SYNC_I,
  input  wire logic [3:0]         GROUP_SIZE,
  input  wire logic [3:0]         ORDER,
  input  wire logic               ORDER_OVERRIDE,
  input  wire logic [6:0]         BUS_ADDR,
  // power stage
  output logic                    POWER_STAGE_EN,
  output logic [11:0]             VREF,
  output logic                    LOW_SIDE_ON,
  output logic                    PWM_START,
  output logic [9:0]              PHASE_OFFSET_CYC,
  // pins
  output logic                    OUTPUT_GOOD_PIN_O,
  output logic                    OUTPUT_GOOD_PIN_OE,
  output logic                    SYNC_O,
  output logic                    SYNC_OE,
  // sticky fault status
  output logic                    OVER_VOLTAGE_GUARD_FLAG,
  output logic                    UNDER_VOLTAGE_GUARD_FLAG,
  output logic                    OVER_CURRENT_GUARD_FLAG,
  output logic                    REVERSE_CURRENT_GUARD_FLAG,
  output ofrc_pkg::ofrc_state_e   SEQ_STATE
);
  // scale nominal by a percentage
  function automatic logic [12:0] pct_of(input logic [11:0] nom, input logic [8:0] pct);
    pct_of = 13'((21'(nom) * 21'(pct)) / 21'(PCT_FULL));
  endfunction

  // zero selects the default percentage
  function automatic logic [7:0] pct_sel(input logic [7:0] val, input logic [7:0] def);
    pct_sel = (val == 8'h00) ? def : val;
  endfunction

  // pick the response of the highest priority active fault
  function automatic ofrc_resp_e resp_of(input logic ov, input logic uv, input logic oc,
                                         input ofrc_resp_e vr, input ofrc_resp_e cr,
                                         input ofrc_resp_e rr);
    resp_of = (ov || uv) ? vr : (oc ? cr : rr);
  endfunction

  logic [2:0]  pin_lvl;
  logic        en_act;
  ofrc_state_e st_reg, st_next;
  logic [7:0]  tmr_reg, tmr_next;
  logic [11:0] tick_reg, tick_next;
  logic [19:0] hic_reg, hic_next;
  logic [1:0]  rty_reg, rty_next;
  logic        cb_reg, cb_next;
  logic [11:0] vref_reg, vref_next;
  logic [7:0]  rcp_reg, rcp_next;
  logic        pg_reg, pg_next;
  logic [7:0]  pgc_reg, pgc_next;
  logic [3:0]  flg_reg, flg_next;
  logic        tick;
  logic        on_stage;
  logic        ov_now, uv_now, oc_now, rc_now, any_fault;
  logic [12:0] vmeas13;
  ofrc_resp_e  resp;
  logic [3:0]  order_eff;

  // sync and comparator pins through the filter
  ofrc_pin_sync #(.W(3)) u_pins (
    .clk       (CLOCK),
    .rst_b     (RST_B),
    .pin_in    ({REVERSE_CURRENT_DET_PIN, OVERCURRENT_DET_PIN, SYNC_I}),
    .level_out (pin_lvl)
  );

  assign order_eff = ORDER_OVERRIDE ? ORDER : {BUS_ADDR[2:0], 1'b0};

  ofrc_phase u_phase (
    .clk        (CLOCK),
    .rst_b      (RST_B),
    .sync_mode  (SYNC_MODE),
    .group_size (GROUP_SIZE),
    .order      (order_eff),
    .sync_lvl   (pin_lvl[0]),
    .pwm_start  (PWM_START),
    .sync_o     (SYNC_O),
    .sync_oe    (SYNC_OE),
    .offset_cyc (PHASE_OFFSET_CYC)
  );

  // enable pin has its own filter so polarity applies to the clean level
  logic en_lvl;
  ofrc_pin_sync #(.W(1)) u_en (
    .clk       (CLOCK),
    .rst_b     (RST_B),
    .pin_in    (ENABLE_PIN),
    .level_out (en_lvl)
  );

  assign en_act = en_lvl ^ ENABLE_ACTIVE_LOW;

  // fault detection
  always_comb begin
    vmeas13  = {1'b0, VOUT_MEAS};
    on_stage = (st_reg == ST_RISE) || (st_reg == ST_REG) ||
               (st_reg == ST_OFF_DLY) || (st_reg == ST_FALL);
    ov_now = on_stage &&
             (vmeas13 > pct_of(VOUT_NOM, PCT_FULL + 9'(pct_sel(OV_PCT, OV_PCT_DEF))));
    uv_now = (st_reg == ST_REG) &&
             (vmeas13 < pct_of(VOUT_NOM, PCT_FULL - 9'(pct_sel(UV_PCT, UV_PCT_DEF))));
    // current guards blanked until ramp-up done
    oc_now = (st_reg == ST_REG) && pin_lvl[1];
    rc_now = (st_reg == ST_REG) && (rcp_reg == 8'(RC_PERSIST_CYC));
    any_fault = ov_now || uv_now || oc_now || rc_now;
    resp = resp_of(ov_now, uv_now, oc_now, VOLTAGE_FAULT_OPTIONS,
                   OVERCURRENT_RESPONSE_SETTING, REVERSE_CURRENT_RESPONSE_SETTING);
    rcp_next = (pin_lvl[2] && st_reg == ST_REG) ?
               ((rcp_reg == 8'(RC_PERSIST_CYC)) ? rcp_reg : rcp_reg + 8'h01) : 8'h00;
    // sticky flags, setting wins over clearing
    flg_next = (CLEAR_FAULTS ? 4'h0 : flg_reg) | {rc_now, oc_now, uv_now, ov_now};
  end

  // output sequencer
  always_comb begin
    st_next   = st_reg;
    rty_next  = rty_reg;
    cb_next   = cb_reg;
    tick      = (tick_reg == 12'(TICK_CYCLES - 1));
    tick_next = tick ? 12'h000 : tick_reg + 12'h001;
    hic_next  = 20'h00000;
    case (st_reg)
      ST_IDLE: begin
        rty_next = 2'h0;
        cb_next  = 1'b0;
        if (en_act)
          st_next = ST_ON_DLY;
      end
      ST_ON_DLY: begin
        if (!en_act)
          st_next = ST_IDLE;
        else if (tmr_reg >= TON_DELAY)
          st_next = ST_RISE;
      end
      ST_RISE, ST_REG: begin
        if (st_reg == ST_RISE && tmr_reg >= TON_RISE)
          st_next = ST_REG;
        if (!en_act)
          st_next = SOFT_STOP_EN ? ST_OFF_DLY : ST_IDLE;
      end
      ST_OFF_DLY: begin
        if (tmr_reg >= TOFF_DELAY)
          st_next = ST_FALL;
      end
      ST_FALL: begin
        if (tmr_reg >= TOFF_FALL)
          st_next = ST_IDLE;
      end
      ST_HICCUP: begin
        // restart reruns the whole start sequence
        hic_next = hic_reg + 20'h00001;
        if (!en_act)
          st_next = ST_IDLE;
        else if (hic_reg >= 20'(HICCUP_CYCLES - 1)) begin
          st_next = ST_ON_DLY;
          cb_next = 1'b0;
        end
      end
      ST_LATCHED: begin
        if (CLEAR_FAULTS || !en_act)
          st_next = ST_IDLE;
      end
      default: st_next = ST_IDLE;
    endcase
    if (any_fault) begin
      cb_next = ov_now && !CROWBAR_DISABLE;
      // hiccup is the zero default; delayed acts as latch
      case (resp)
        RESP_HICCUP: st_next = ST_HICCUP;
        RESP_RETRY: begin
          if (rty_reg < RETRY_LIMIT) begin
            st_next  = ST_HICCUP;
            rty_next = rty_reg + 2'h1;
          end else
            st_next = ST_LATCHED;
        end
        default: st_next = ST_LATCHED;
      endcase
    end
    tmr_next = (st_next != st_reg) ? 8'h00 :
               ((tick && tmr_reg != 8'hFF) ? tmr_reg + 8'h01 : tmr_reg);
  end

  // reference ramps up over rise time and down over fall time
  always_comb begin
    case (st_next)
      ST_RISE: vref_next = (TON_RISE == 8'h00) ? VOUT_NOM :
                           12'((20'(VOUT_NOM) * 20'(tmr_next)) / 20'(TON_RISE));
      ST_REG, ST_OFF_DLY: vref_next = VOUT_NOM;
      ST_FALL: vref_next = (TOFF_FALL == 8'h00) ? 12'h000 :
                           12'((20'(VOUT_NOM) * 20'(TOFF_FALL - tmr_next)) / 20'(TOFF_FALL));
      default: vref_next = 12'h000;
    endcase
  end

  always_comb begin
    pg_next  = 1'b0;
    pgc_next = 8'h00;
    if (st_reg == ST_REG && !any_fault) begin
      if (pg_reg)
        pg_next = vmeas13 >=
                  pct_of(VOUT_NOM, 9'(pct_sel(PGOOD_OFF_PCT, PGOFF_PCT_DEF)));
      else if (vmeas13 > pct_of(VOUT_NOM, 9'(pct_sel(PGOOD_ON_PCT, PGON_PCT_DEF)))) begin
        pgc_next = (tick && pgc_reg != 8'hFF) ? pgc_reg + 8'h01 : pgc_reg;
        pg_next  = (pgc_reg >= PGOOD_DELAY);
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      st_reg   <= ST_IDLE;
      tmr_reg  <= 8'h00;
      tick_reg <= 12'h000;
      hic_reg  <= 20'h00000;
      rty_reg  <= 2'h0;
      cb_reg   <= 1'b0;
      vref_reg <= 12'h000;
      rcp_reg  <= 8'h00;
      pg_reg   <= 1'b0;
      pgc_reg  <= 8'h00;
      flg_reg  <= 4'h0;
    end else begin
      st_reg   <= st_next;
      tmr_reg  <= tmr_next;
      tick_reg <= tick_next;
      hic_reg  <= hic_next;
      rty_reg  <= rty_next;
      cb_reg   <= cb_next;
      vref_reg <= vref_next;
      rcp_reg  <= rcp_next;
      pg_reg   <= pg_next;
      pgc_reg  <= pgc_next;
      flg_reg  <= flg_next;
    end
  end

  // outputs
  assign POWER_STAGE_EN  = on_stage;
  assign VREF            = vref_reg;
  assign LOW_SIDE_ON     = cb_reg;
  assign SEQ_STATE       = st_reg;
  // open drain pulls low only; push-pull always drives
  assign OUTPUT_GOOD_PIN_O  = VENDOR_CONFIG_PUSH_PULL && pg_reg;
  assign OUTPUT_GOOD_PIN_OE = VENDOR_CONFIG_PUSH_PULL || !pg_reg;
  assign {REVERSE_CURRENT_GUARD_FLAG, OVER_CURRENT_GUARD_FLAG,
          UNDER_VOLTAGE_GUARD_FLAG, OVER_VOLTAGE_GUARD_FLAG} = flg_reg;

  sequence s_enter_on_dly;
    st_reg != ST_ON_DLY ##1 st_reg == ST_ON_DLY;
  endsequence

  chk_pg_low_ramp : assert property (
    @(posedge CLOCK) disable iff (!RST_B)
    (st_reg != ST_REG || any_fault) |=> !pg_reg)
    else $error("output good high outside regulation");

  chk_ov_shutdown : assert property (
    @(posedge CLOCK) disable iff (!RST_B)
    ov_now |=> (st_reg == ST_HICCUP || st_reg == ST_LATCHED) && !POWER_STAGE_EN)
    else $error("over-voltage did not shut the output down");

  chk_crowbar_on : assert property (
    @(posedge CLOCK) disable iff (!RST_B)
    (ov_now && !CROWBAR_DISABLE) |=> LOW_SIDE_ON)
    else $error("crowbar not applied on over-voltage");

  chk_oc_blanked : assert property (
    @(posedge CLOCK) disable iff (!RST_B)
    (st_reg == ST_RISE && !ov_now && en_act && tmr_reg < TON_RISE) |=> st_reg == ST_RISE)
    else $error("ramp left early, current guard not blanked");

  chk_latch_hold : assert property (
    @(posedge CLOCK) disable iff (!RST_B)
    (st_reg == ST_LATCHED && !CLEAR_FAULTS && en_act) |=> st_reg == ST_LATCHED)
    else $error("latched fault released without clear or re-enable");

  chk_ondelay_ramp : assert property (
    @(posedge CLOCK) disable iff (!RST_B)
    s_enter_on_dly |-> !POWER_STAGE_EN [*2])
    else $error("power stage on during on-delay");

  chk_hard_stop : assert property (
    @(posedge CLOCK) disable iff (!RST_B)
    (st_reg == ST_REG && !en_act && !SOFT_STOP_EN && !any_fault) |=> st_reg == ST_IDLE)
    else $error("output not stopped at once with soft-stop off");

  chk_pg_delay : assert property (
    @(posedge CLOCK) disable iff (!RST_B)
    $rose(pg_reg) |-> $past(pgc_reg) >= PGOOD_DELAY)
    else $error("output good asserted before its delay");

  chk_pg_open_drain : assert property (
    @(posedge CLOCK) disable iff (!RST_B)
    !VENDOR_CONFIG_PUSH_PULL |-> !OUTPUT_GOOD_PIN_O && (OUTPUT_GOOD_PIN_OE == !pg_reg))
    else $error("open drain output good drives high");
endmodule
`default_nettype wire

/* logic/ofrc_phase.sv */
`timescale 1ns/1ps
`default_nettype none
module ofrc_phase
  import ofrc_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // configuration
  input  wire ofrc_pkg::ofrc_sync_e sync_mode,
  input  wire logic [3:0]       group_size,
  input  wire logic [3:0]       order,
  // filtered sync pin level
  input  wire logic             sync_lvl,
  // results
  output logic                  pwm_start,
  output logic                  sync_o,
  output logic                  sync_oe,
  output logic [9:0]            offset_cyc
);
  logic [9:0] per_reg, per_next;
  logic [9:0] dly_reg, dly_next;
  logic       arm_reg, arm_next;
  logic       prev_reg, prev_next;
  logic       so_reg, so_next;
  logic [4:0] size_eff;
  logic       ref_edge;
  logic [9:0] since_reg;
  logic [9:0] ofs_reg;
  logic [9:0] offset_mod;

  always_comb begin
    size_eff   = (group_size == GROUP_ZERO) ? GROUP_FULL : {1'b0, group_size};
    offset_cyc = 10'((14'(order) * 14'(SW_PERIOD_CYC)) / 14'(size_eff));
    // offsets past a full turn wrap, else the next edge re-arms before the start
    offset_mod = offset_cyc % 10'(SW_PERIOD_CYC);
  end

  always_comb begin
    if (sync_mode == SYNC_INPUT)
      ref_edge = sync_lvl && !prev_reg;
    else
      ref_edge = (per_reg == 10'h000);
  end

  // delay pwm start after reference edge
  always_comb begin
    per_next  = (per_reg == 10'(SW_PERIOD_CYC - 1)) ? 10'h000 : per_reg + 10'h001;
    prev_next = sync_lvl;
    dly_next  = dly_reg;
    arm_next  = arm_reg;
    pwm_start = arm_reg && (dly_reg == 10'h000);
    if (pwm_start)
      arm_next = 1'b0;
    else if (arm_reg)
      dly_next = dly_reg - 10'h001;
    if (ref_edge) begin
      dly_next = offset_mod;
      arm_next = 1'b1;
    end
    // drive local clock when configured as source
    so_next = (sync_mode == SYNC_OUTPUT) && (per_next < 10'(SW_PERIOD_CYC / 2));
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      per_reg  <= 10'h000;
      dly_reg  <= 10'h000;
      arm_reg  <= 1'b0;
      prev_reg <= 1'b0;
      so_reg   <= 1'b0;
    end else begin
      per_reg  <= per_next;
      dly_reg  <= dly_next;
      arm_reg  <= arm_next;
      prev_reg <= prev_next;
      so_reg   <= so_next;
    end
  end

  assign sync_o  = so_reg;
  assign sync_oe = (sync_mode == SYNC_OUTPUT);

  // cycles since last reference edge and the offset taken there, for checking only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      since_reg <= 10'h3FF;
      ofs_reg   <= 10'h000;
    end else if (ref_edge) begin
      since_reg <= 10'h000;
      ofs_reg   <= offset_mod;
    end else if (since_reg != 10'h3FF)
      since_reg <= since_reg + 10'h001;
  end

  chk_phase_offset_delay : assert property (
    @(posedge clk) disable iff (!rst_b)
    (pwm_start && since_reg < 10'h3FF) |-> (since_reg == ofs_reg))
    else $error("pwm start not at the configured phase offset");

  chk_sync_pin_ignored : assert property (
    @(posedge clk) disable iff (!rst_b)
    (sync_mode == SYNC_INTERNAL && per_reg != 10'h000) |-> !ref_edge)
    else $error("sync pin used while internal clock selected");
endmodule
`default_nettype wire

/* logic/ofrc_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module ofrc_pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // pins in, filtered levels out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);
  // three stages per pin, level follows once stages two and three agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic lvl_reg;
    logic lvl_next;

    always_comb begin
      lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
    end

    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        s1_reg  <= 1'b0;
        s2_reg  <= 1'b0;
        s3_reg  <= 1'b0;
        lvl_reg <= 1'b0;
      end else begin
        s1_reg  <= pin_in[i];
        s2_reg  <= s1_reg;
        s3_reg  <= s2_reg;
        lvl_reg <= lvl_next;
      end
    end

    assign level_out[i] = lvl_reg;
  end
endmodule
`default_nettype wire

/* logic/ofrc_pkg.sv */
package ofrc_pkg;
  // clock and time base
  localparam int CLK_MHZ          = 20;
  localparam int TICK_US          = 100;
  localparam int TICK_CYCLES      = TICK_US * CLK_MHZ;
  localparam int HICCUP_TIME_US   = 10000;
  localparam int HICCUP_CYC_DEF   = HICCUP_TIME_US * CLK_MHZ;
  localparam int RC_PERSIST_US    = 10;
  localparam int RC_PERSIST_CYC   = RC_PERSIST_US * CLK_MHZ;
  localparam int SW_FREQ_KHZ      = 500;
  localparam int SW_PERIOD_CYC    = (CLK_MHZ * 1000) / SW_FREQ_KHZ;

  // percent defaults, a port value of zero selects these
  localparam logic [8:0] PCT_FULL    = 9'h064;
  localparam logic [7:0] OV_PCT_DEF  = 8'h0F;
  localparam logic [7:0] UV_PCT_DEF  = 8'h0F;
  localparam logic [7:0] PGON_PCT_DEF = 8'h5A;
  localparam logic [7:0] PGOFF_PCT_DEF = 8'h55;

  // restart limit of the counted response
  localparam logic [1:0] RETRY_LIMIT = 2'h3;

  // interleave fields
  localparam logic [4:0] GROUP_FULL = 5'h10;
  localparam logic [3:0] GROUP_ZERO = 4'h0;

  // fault responses, zero is the reset default
  typedef enum logic [1:0] {
    RESP_HICCUP  = 2'b00,
    RESP_LATCH   = 2'b01,
    RESP_RETRY   = 2'b10,
    RESP_DELAYED = 2'b11
  } ofrc_resp_e;

  // sync pin usage, zero is the reset default
  typedef enum logic [1:0] {
    SYNC_INTERNAL = 2'b00,
    SYNC_INPUT    = 2'b01,
    SYNC_OUTPUT   = 2'b10,
    SYNC_RSVD     = 2'b11
  } ofrc_sync_e;

  // output sequencer
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ON_DLY  = 3'b001,
    ST_RISE    = 3'b010,
    ST_REG     = 3'b011,
    ST_OFF_DLY = 3'b100,
    ST_FALL    = 3'b101,
    ST_HICCUP  = 3'b110,
    ST_LATCHED = 3'b111
  } ofrc_state_e;
endpackage

/* testbench/ofrc_core_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module ofrc_core_tb;
  import ofrc_pkg::*;
  typedef struct {int sel; logic [11:0] val;} ofrc_note_s;
  localparam int S_ST = 0, S_VR = 1, S_PH = 2, S_EN = 3, S_OE = 4, S_O = 5, S_LS = 6;
  localparam int S_OV = 7, S_OC = 8, S_SY = 9, S_RC = 10, S_UV = 11, S_SO = 12, S_PW = 13;
  // stimulus
  logic CLOCK = 1'b0, RST_B = 1'b0, ENABLE_PIN = 1'b0, ENABLE_ACTIVE_LOW = 1'b0;
  logic CLEAR_FAULTS = 1'b0, OVERCURRENT_DET_PIN = 1'b0, REVERSE_CURRENT_DET_PIN = 1'b0;
  logic CROWBAR_DISABLE = 1'b0, VENDOR_CONFIG_PUSH_PULL = 1'b0, SOFT_STOP_EN = 1'b0;
  logic ORDER_OVERRIDE = 1'b0;
  logic [11:0] VOUT_NOM = 12'h400, BUMP = 12'h000;
  logic [7:0] OV_PCT = 8'h00, UV_PCT = 8'h00, PGOOD_ON_PCT = 8'h00, PGOOD_OFF_PCT = 8'h00;
  logic [7:0] PGOOD_DELAY = 8'h02, TON_DELAY = 8'h01, TON_RISE = 8'h02;
  logic [7:0] TOFF_DELAY = 8'h01, TOFF_FALL = 8'h01;
  logic [3:0] GROUP_SIZE = 4'h0, ORDER = 4'h0;
  logic [6:0] BUS_ADDR = 7'h00;
  ofrc_resp_e VOLTAGE_FAULT_OPTIONS = RESP_HICCUP, REVERSE_CURRENT_RESPONSE_SETTING = RESP_HICCUP;
  ofrc_resp_e OVERCURRENT_RESPONSE_SETTING = RESP_LATCH;
  ofrc_sync_e SYNC_MODE = SYNC_INTERNAL;
  // design and partner outputs
  logic [11:0] VOUT_MEAS, VREF;
  logic [9:0] PHASE_OFFSET_CYC;
  logic SYNC_I, POWER_STAGE_EN, LOW_SIDE_ON, PWM_START, SYNC_O, SYNC_OE;
  logic OUTPUT_GOOD_PIN_O, OUTPUT_GOOD_PIN_OE, OVER_VOLTAGE_GUARD_FLAG;
  logic UNDER_VOLTAGE_GUARD_FLAG, OVER_CURRENT_GUARD_FLAG, REVERSE_CURRENT_GUARD_FLAG;
  ofrc_state_e SEQ_STATE;
  // checking state
  ofrc_note_s q[$];
  ofrc_note_s n;
  event obs, done;
  int miscompares = 0;
  int cmp_count = 0;
  int ordv;
  logic [31:0] seed = 32'hDA30C487;
  wire logic [10:0] bits = {PWM_START, SYNC_O, UNDER_VOLTAGE_GUARD_FLAG,
    REVERSE_CURRENT_GUARD_FLAG, SYNC_OE, OVER_CURRENT_GUARD_FLAG,
    OVER_VOLTAGE_GUARD_FLAG, LOW_SIDE_ON, OUTPUT_GOOD_PIN_O, OUTPUT_GOOD_PIN_OE, POWER_STAGE_EN};
  // design with a short hiccup interval
  ofrc_core #(.HICCUP_CYCLES(50)) i_ofrc_core (
    .CLOCK, .RST_B, .ENABLE_PIN, .ENABLE_ACTIVE_LOW, .CLEAR_FAULTS, .VOUT_MEAS, .VOUT_NOM,
    .OVERCURRENT_DET_PIN, .REVERSE_CURRENT_DET_PIN, .OV_PCT, .UV_PCT, .VOLTAGE_FAULT_OPTIONS,
    .CROWBAR_DISABLE, .OVERCURRENT_RESPONSE_SETTING, .REVERSE_CURRENT_RESPONSE_SETTING,
    .PGOOD_ON_PCT, .PGOOD_OFF_PCT, .PGOOD_DELAY, .VENDOR_CONFIG_PUSH_PULL, .TON_DELAY,
    .TON_RISE, .TOFF_DELAY, .TOFF_FALL, .SOFT_STOP_EN, .SYNC_MODE, .SYNC_I, .GROUP_SIZE,
    .ORDER, .ORDER_OVERRIDE, .BUS_ADDR, .POWER_STAGE_EN, .VREF, .LOW_SIDE_ON, .PWM_START,
    .PHASE_OFFSET_CYC, .OUTPUT_GOOD_PIN_O, .OUTPUT_GOOD_PIN_OE, .SYNC_O, .SYNC_OE,
    .OVER_VOLTAGE_GUARD_FLAG, .UNDER_VOLTAGE_GUARD_FLAG, .OVER_CURRENT_GUARD_FLAG,
    .REVERSE_CURRENT_GUARD_FLAG, .SEQ_STATE);
  // far side: output filter and external clock
  ofrc_plant i_ofrc_plant (.clk(CLOCK), .rst_b(RST_B), .stage_en(POWER_STAGE_EN), .vref(VREF),
    .bump(BUMP), .sync_run(SYNC_MODE != SYNC_OUTPUT), .vout(VOUT_MEAS), .sync_line(SYNC_I));
  // clock
  always #25 CLOCK = ~CLOCK;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [11:0] got(input int s);
    case (s)
      S_ST: return {9'h000, SEQ_STATE};
      S_VR: return VREF;
      S_PH: return {2'b00, PHASE_OFFSET_CYC};
      default: return {11'h000, bits[s-3]};
    endcase
  endfunction
  task automatic tk(input int c);
    repeat (c) @(posedge CLOCK);
    #2;
  endtask
  task automatic note(input int s, input logic [11:0] v);
    q.push_back('{s, v});
    ->obs;
    // wait for the compare so that later stimulus cannot race it
    @(done);
  endtask
  // bounded wait for an output value, then log it
  task automatic wait_v(input int s, input logic [11:0] v, input int lim);
    int k;
    k = 0;
    while (got(s) !== v && k < lim) begin
      tk(1);
      k++;
    end
    note(s, v);
  endtask
  task automatic wait_st(input ofrc_state_e st, input int lim);
    wait_v(S_ST, {9'h000, st}, lim);
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // monitor: compare oldest note against outputs
  initial forever begin
    @(obs);
    while (q.size() > 0) begin
      n = q.pop_front();
      cmp_count++;
      if (got(n.sel) !== n.val) begin
        miscompares++;
        $display("[ERR] %0t sel %0d got %h exp %h", $time, n.sel, got(n.sel), n.val);
      end
    end
    ->done;
  end
  // watchdog
  initial begin
    #5000000;
    miscompares++;
    wrap_up();
  end
  // main sequence
  initial begin
    tk(12);
    RST_B = 1'b1;
    tk(2);
    wait_st(ST_IDLE, 1);
    note(S_OE, 12'h001);
    note(S_O, 12'h000);
    note(S_SY, 12'h000);
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      GROUP_SIZE = seed[3:0];
      ORDER = seed[7:4];
      BUS_ADDR = seed[14:8];
      ORDER_OVERRIDE = seed[15];
      tk(1);
      ordv = ORDER_OVERRIDE ? ORDER : {BUS_ADDR[2:0], 1'b0};
      note(S_PH, 12'(ordv * 40 / (GROUP_SIZE == 4'h0 ? 16 : GROUP_SIZE)));
    end
    // current fault ignored during ramp, latched after
    ENABLE_PIN = 1'b1;
    wait_st(ST_RISE, 9000);
    note(S_EN, 12'h001);
    note(S_OE, 12'h001);
    OVERCURRENT_DET_PIN = 1'b1;
    tk(100);
    wait_st(ST_RISE, 1);
    wait_st(ST_LATCHED, 9000);
    note(S_OC, 12'h001);
    OVERCURRENT_DET_PIN = 1'b0;
    tk(8);
    CLEAR_FAULTS = 1'b1;
    tk(1);
    CLEAR_FAULTS = 1'b0;
    tk(1);
    note(S_OC, 12'h000);
    wait_st(ST_REG, 12000);
    note(S_VR, 12'h400);
    tk(1000);
    note(S_OE, 12'h001);
    wait_v(S_OE, 12'h000, 5000);
    VENDOR_CONFIG_PUSH_PULL = 1'b1;
    tk(1);
    note(S_O, 12'h001);
    // over-voltage with default hiccup and crowbar
    BUMP = 12'h100;
    wait_st(ST_HICCUP, 10);
    tk(1);
    note(S_OV, 12'h001);
    note(S_LS, 12'h001);
    note(S_O, 12'h000);
    BUMP = 12'h000;
    wait_st(ST_ON_DLY, 60);
    // latch-off without crowbar, left by disable
    wait_st(ST_REG, 12000);
    VOLTAGE_FAULT_OPTIONS = RESP_LATCH;
    CROWBAR_DISABLE = 1'b1;
    BUMP = 12'h100;
    wait_st(ST_LATCHED, 10);
    note(S_LS, 12'h000);
    BUMP = 12'h000;
    tk(300);
    wait_st(ST_LATCHED, 1);
    ENABLE_PIN = 1'b0;
    wait_st(ST_IDLE, 10);
    // sustained reverse current
    VOLTAGE_FAULT_OPTIONS = RESP_HICCUP;
    ENABLE_PIN = 1'b1;
    wait_st(ST_REG, 12000);
    REVERSE_CURRENT_DET_PIN = 1'b1;
    wait_st(ST_HICCUP, 260);
    note(S_RC, 12'h001);
    REVERSE_CURRENT_DET_PIN = 1'b0;
    wait_st(ST_REG, 12000);
    // under-voltage with default hiccup
    BUMP = 12'hF00;
    wait_st(ST_HICCUP, 10);
    note(S_UV, 12'h001);
    BUMP = 12'h000;
    wait_st(ST_REG, 12000);
    ENABLE_PIN = 1'b0;
    wait_st(ST_IDLE, 6);
    // soft-stop
    SOFT_STOP_EN = 1'b1;
    ENABLE_PIN = 1'b1;
    wait_st(ST_REG, 12000);
    ENABLE_PIN = 1'b0;
    wait_st(ST_OFF_DLY, 6);
    note(S_EN, 12'h001);
    wait_st(ST_FALL, 5000);
    wait_st(ST_IDLE, 5000);
    note(S_VR, 12'h000);
    // enable polarity, sync pin direction, phase offset, counted restarts
    OVERCURRENT_RESPONSE_SETTING = RESP_RETRY;
    OVERCURRENT_DET_PIN = 1'b1;
    ENABLE_ACTIVE_LOW = 1'b1;
    wait_st(ST_ON_DLY, 8);
    SYNC_MODE = SYNC_OUTPUT;
    tk(1);
    note(S_SY, 12'h001);
    ORDER_OVERRIDE = 1'b1;
    ORDER = 4'h1;
    GROUP_SIZE = 4'h4;
    wait_v(S_SO, 12'h000, 40);
    wait_v(S_SO, 12'h001, 40);
    tk(11);
    note(S_PW, 12'h001);
    tk(1);
    note(S_PW, 12'h000);
    SYNC_MODE = SYNC_INPUT;
    tk(1);
    note(S_SY, 12'h000);
    for (int i = 0; i < 3; i++) begin
      wait_st(ST_HICCUP, 6100);
      wait_st(ST_ON_DLY, 60);
    end
    wait_st(ST_LATCHED, 6100);
    note(S_OC, 12'h001);
    tk(2);
    wrap_up();
  end
endmodule
`default_nettype wire

/* testbench/ofrc_plant.sv */
`timescale 1ns/1ps
`default_nettype none
module ofrc_plant (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // power stage and injected error
  input  wire logic        stage_en,
  input  wire logic [11:0] vref,
  input  wire logic [11:0] bump,
  input  wire logic        sync_run,
  // measured output and sync line
  output logic      [11:0] vout,
  output logic             sync_line
);
  logic [5:0] ph_reg;
  // output tracks reference, collapses with stage off
  assign vout = stage_en ? vref + bump : 12'h000;
  // free 40-cycle phase counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      ph_reg <= 6'h00;
    else
      ph_reg <= (ph_reg == 6'h27) ? 6'h00 : ph_reg + 6'h01;
  end
  assign sync_line = sync_run & (ph_reg < 6'h14);
endmodule
`default_nettype wire
